// >>> mcpwm_chan.sv
// Purpose : one pulse width channel: period counter with double-buffered settings
// Assumes : per and hi are valid in the cycle that load is high
// Notes   : a period of zero means the channel is idle and its output is low
`timescale 1ns/1ps
module mcpwm_chan #(
    parameter int unsigned PER_W = mcpwm_pkg::PER_W
) (
    input  wire logic             i_clk,
    input  wire logic             i_rst_n,
    input  wire logic             i_ce,
    input  wire logic             i_load,
    input  wire logic [PER_W-1:0] i_per,
    input  wire logic [PER_W-1:0] i_hi,
    output logic                  o_pwm
);
    import mcpwm_pkg::*;

    logic [PER_W-1:0] per_q, per_d, hi_q, hi_d, cnt_q, cnt_d;
    logic [PER_W-1:0] pper_q, pper_d, phi_q, phi_d;
    logic             pend_q, pend_d, out_q, out_d;
    logic             bound;

    // ---------------------------------------------------------------
    // counter and shadow settings
    // ---------------------------------------------------------------
    // new settings wait for the period boundary so no pulse is cut short
    always_comb begin
        per_d  = per_q;
        hi_d   = hi_q;
        pper_d = pper_q;
        phi_d  = phi_q;
        pend_d = pend_q;
        cnt_d  = cnt_q + PER_W'(1);
        bound  = (per_q == '0) || (cnt_q == per_q - PER_W'(1));
        if (i_load) begin
            pper_d = i_per;
            phi_d  = i_hi;
            pend_d = 1'b1;
        end
        if (bound) begin
            cnt_d = '0;
            if (i_load) begin                           // newest write wins at the edge
                per_d  = i_per;
                hi_d   = i_hi;
                pend_d = 1'b0;
            end else if (pend_q) begin
                per_d  = pper_q;
                hi_d   = phi_q;
                pend_d = 1'b0;
            end
        end
        // high for a cycles then low for b; hi 0 never high, hi = per never low
        out_d = (per_d != '0) && (cnt_d < hi_d);
    end

    // settings and counter registers; a low clock enable freezes them
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            per_q  <= '0;
            hi_q   <= '0;
            pper_q <= '0;
            phi_q  <= '0;
            pend_q <= 1'b0;
            cnt_q  <= '0;
            out_q  <= 1'b0;
        end else if (i_ce) begin
            per_q  <= per_d;
            hi_q   <= hi_d;
            pper_q <= pper_d;
            phi_q  <= phi_d;
            pend_q <= pend_d;
            cnt_q  <= cnt_d;
            out_q  <= out_d;
        end
    end

    assign o_pwm = out_q;

endmodule

// >>> mcpwm_load.sv
// Purpose : load on one output, measuring on time and period in core cycles
// Assumes : same clock as the generator
// Notes   : counts edges so a constant output can be seen as such
`timescale 1ns/1ps
module mcpwm_load
    import mcpwm_pkg::*;
(
    input  wire logic                        i_clk,
    input  wire logic                        i_pin,
    output logic [mcpwm_pkg::PER_W-1:0]      o_hi,
    output logic [mcpwm_pkg::PER_W-1:0]      o_per,
    output int unsigned                      o_edges
);
    logic                 prev_q = 1'b0;
    logic [PER_W-1:0]     cnt_q = '0;
    logic [PER_W-1:0]     hi_q = '0;
    logic [PER_W-1:0]     per_q = '0;
    int unsigned          edges_q = 0;
    // a rising edge closes one period a+b, a falling edge closes the on time a
    always_ff @(posedge i_clk) begin
        prev_q <= i_pin;
        cnt_q <= (i_pin && !prev_q) ? PER_W'(1) : cnt_q + PER_W'(1);
        if (i_pin && !prev_q) per_q <= cnt_q;
        if (!i_pin && prev_q) hi_q <= cnt_q;
        if (i_pin != prev_q) edges_q <= edges_q + 1;
    end
    assign o_hi = hi_q;
    assign o_per = per_q;
    assign o_edges = edges_q;
endmodule

// >>> mcpwm_monitor.sv
// Purpose : port checker for the four-channel pulse width generator
// Assumes : I_CE is held high while checked
// Notes   : bound to the top module from the testbench top
`timescale 1ns/1ps
module mcpwm_monitor
    import mcpwm_pkg::*;
(
    input wire logic                       I_CORE_CLK,
    input wire logic                       I_RST_N,
    input wire logic                       I_CMD_VALID,
    input wire logic [mcpwm_pkg::CH_W-1:0] I_CMD_CHANNEL,
    input wire logic                       O_CMD_READY,
    input wire logic                       O_DOUT5,
    input wire logic                       O_DOUT6,
    input wire logic                       O_DOUT7,
    input wire logic                       O_DOUT8
);
    logic       acc;
    logic [3:0] set_q;
    logic       any_q;
    assign acc = I_CMD_VALID && O_CMD_READY;
    // channels never commanded must keep their pin low, so remember them
    always_ff @(posedge I_CORE_CLK) begin
        if (!I_RST_N) begin
            set_q <= 4'h0;
            any_q <= 1'b0;
        end else if (acc) begin
            set_q[I_CMD_CHANNEL] <= 1'b1;
            any_q <= 1'b1;
        end
    end
    default clocking @(posedge I_CORE_CLK); endclocking
    default disable iff (!I_RST_N);
    sequence s_busy;
        (!O_CMD_READY)[*8] ##58 !O_CMD_READY;
    endsequence
    a_busy_span: assert property (acc |=> s_busy ##1 O_CMD_READY)
        else $error("ready span after a command is wrong");
    a_ready_cause: assert property ($rose(O_CMD_READY) && any_q |-> $past(acc, 67))
        else $error("ready rose without a command 67 cycles before");
    a_reset_quiet: assert property (disable iff (1'b0) !I_RST_N |=>
        !(O_CMD_READY | O_DOUT5 | O_DOUT6 | O_DOUT7 | O_DOUT8)) else $error("outputs live in reset");
    a_ready_wake: assert property ($rose(I_RST_N) |-> !O_CMD_READY ##[1:2] O_CMD_READY)
        else $error("ready did not come up after reset");
    a_pin5_idle: assert property (!set_q[PIN5_CH] |-> !O_DOUT5)
        else $error("output five active before its channel was set");
    a_pin6_idle: assert property (!set_q[PIN6_CH] |-> !O_DOUT6)
        else $error("output six active before its channel was set");
    a_pin7_idle: assert property (!set_q[PIN7_CH] |-> !O_DOUT7)
        else $error("output seven active before its channel was set");
    a_pin8_idle: assert property (!set_q[PIN8_CH] |-> !O_DOUT8)
        else $error("output eight active before its channel was set");
endmodule

// >>> mcpwm_pkg.sv
// Purpose : shared constants and types for the four-channel pulse width generator
// Assumes : core clock of 25 MHz, commands from logic on the same clock
// Notes   : duty in hundredths of a percent, frequency in whole hertz
package mcpwm_pkg;

    // ---------------------------------------------------------------
    // clock and ranges
    // ---------------------------------------------------------------
    localparam int unsigned CORE_CLK_HZ = 25_000_000;
    localparam int unsigned NUM_CH      = 4;
    localparam int unsigned CH_W        = 2;
    localparam int unsigned DUTY_W      = 14;
    localparam int unsigned FREQ_W      = 16;
    localparam int unsigned PER_W       = 20;   // 25e6/50 = 500000 fits
    localparam int unsigned NUM_W       = 33;   // period * 10000 fits
    localparam int unsigned REM_W       = 16;
    localparam int unsigned STEP_W      = 6;

    localparam logic [FREQ_W-1:0] FREQ_MIN_HZ = 16'h0032;  // 50 Hz
    localparam logic [FREQ_W-1:0] FREQ_MAX_HZ = 16'hC350;  // 50 kHz
    localparam logic [DUTY_W-1:0] DUTY_FULL   = 14'h2710;  // 10000 = 100.00 %
    localparam logic [STEP_W-1:0] DIV_LAST    = 6'h20;     // 33 divide steps

    // ---------------------------------------------------------------
    // output pin mapping: digital output 5..8 -> channel index
    // ---------------------------------------------------------------
    localparam logic [CH_W-1:0] PIN5_CH = 2'h2;  // channel 3
    localparam logic [CH_W-1:0] PIN6_CH = 2'h3;  // channel 4
    localparam logic [CH_W-1:0] PIN7_CH = 2'h0;  // channel 1
    localparam logic [CH_W-1:0] PIN8_CH = 2'h1;  // channel 2

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_DIV_PER,
        ST_DIV_HI
    } mcpwm_state_e;

endpackage

// >>> mcpwm_top.sv
// Contract
// - four independent channels, each with its own frequency and duty.
// - channels drive outputs five to eight; channel 3 on five, 2 on eight.
// - duty is an integer in hundredths of a percent, 0 to 10000.
// - frequency selectable from 50 Hz up to 50 kHz.
// - low-end frequency error under 0.01 percent.
// - frequency error under 0.5 percent at 10 kHz.
// - output on for a, off for b, repeating; period a+b, duty a/(a+b).
//
// Purpose : command decoder and period/high-time computation for four channels
// Assumes : command inputs come from logic on I_CORE_CLK
// Notes   : one command takes about 67 cycles to compute; ready is low meanwhile
`timescale 1ns/1ps
module mcpwm_top
    import mcpwm_pkg::*;
#(
    parameter int unsigned CLK_HZ = mcpwm_pkg::CORE_CLK_HZ
) (
    input  wire logic                          I_CORE_CLK,
    input  wire logic                          I_RST_N,
    input  wire logic                          I_CE,
    input  wire logic                          I_CMD_VALID,
    input  wire logic [mcpwm_pkg::CH_W-1:0]    I_CMD_CHANNEL,
    input  wire logic [mcpwm_pkg::DUTY_W-1:0]  I_CMD_DUTY,
    input  wire logic [mcpwm_pkg::FREQ_W-1:0]  I_CMD_FREQ_HZ,
    output logic                               O_CMD_READY,
    output logic                               O_DOUT5,
    output logic                               O_DOUT6,
    output logic                               O_DOUT7,
    output logic                               O_DOUT8
);
    import mcpwm_pkg::*;

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    // keep requests inside the documented range rather than reject them
    function automatic logic [FREQ_W-1:0] clamp_freq(input logic [FREQ_W-1:0] f);
        if (f < FREQ_MIN_HZ)
            return FREQ_MIN_HZ;
        if (f > FREQ_MAX_HZ)
            return FREQ_MAX_HZ;
        return f;
    endfunction

    // a duty above full scale is taken as always on
    function automatic logic [DUTY_W-1:0] clamp_duty(input logic [DUTY_W-1:0] d);
        return (d > DUTY_FULL) ? DUTY_FULL : d;
    endfunction

    // both divide passes end on the same step count
    function automatic logic last_step(input logic [STEP_W-1:0] s);
        return s == DIV_LAST;
    endfunction

    // one restoring step: returns {quotient bit, new remainder}
    function automatic logic [REM_W:0] div_step(input logic [REM_W-1:0] rem,
                                                input logic             nbit,
                                                input logic [FREQ_W-1:0] den);
        logic [REM_W:0] trial;
        trial = {rem, nbit};
        if (trial >= {1'b0, den})
            return {1'b1, REM_W'(trial - {1'b0, den})};
        return {1'b0, trial[REM_W-1:0]};
    endfunction

    // ---------------------------------------------------------------
    // command and divider state
    // ---------------------------------------------------------------
    // one command runs two restoring divisions back to back:
    //   pass one : period  = CLK_HZ / freq          (33 steps)
    //   pass two : on time = period * duty / 10000  (33 steps)
    // both quotients truncate, so the period is short by less than one
    // core cycle; at 10 kHz that stays under 0.04 percent of the period.
    // the serial divider costs 66 cycles per command but needs no wide
    // divide array; commands are rare next to the waveform periods.
    // ready stays low for the whole computation and a valid seen while
    // ready is low is simply ignored, nothing is queued.
    // the load strobe to the channel and the rise of ready share an edge,
    // so a follow-up command can never overtake the one still pending.
    // only one divider serves all four channels; a channel that is not
    // addressed keeps its settings and its counter untouched.
    //
    mcpwm_state_e      st_q, st_d;
    logic [STEP_W-1:0] step_q, step_d;
    logic [REM_W-1:0]  rem_q, rem_d;
    logic [NUM_W-1:0]  num_q, num_d, quo_q, quo_d;
    logic [FREQ_W-1:0] den_q, den_d;
    logic [CH_W-1:0]   ch_q, ch_d;
    logic [DUTY_W-1:0] duty_q, duty_d;
    logic [PER_W-1:0]  per_q, per_d, hi_q, hi_d;
    logic [NUM_CH-1:0] load_q, load_d;
    logic              ready_q, ready_d;
    logic [REM_W:0]    st_res;
    logic [NUM_W-1:0]  quo_nx;

    // the whole command is taken in one cycle, duty and frequency together
    always_comb begin
        st_d    = st_q;
        step_d  = step_q + STEP_W'(1);
        rem_d   = rem_q;
        num_d   = {num_q[NUM_W-2:0], 1'b0};
        quo_d   = quo_q;
        den_d   = den_q;
        ch_d    = ch_q;
        duty_d  = duty_q;
        per_d   = per_q;
        hi_d    = hi_q;
        load_d  = '0;
        ready_d = ready_q;
        st_res  = div_step(rem_q, num_q[NUM_W-1], den_q);
        quo_nx  = {quo_q[NUM_W-2:0], st_res[REM_W]};
        case (st_q)
            ST_IDLE: begin
                step_d  = '0;
                num_d   = num_q;
                ready_d = 1'b1;                                     // idle means ready
                if (I_CMD_VALID && ready_q) begin
                    ch_d    = I_CMD_CHANNEL;
                    duty_d  = clamp_duty(I_CMD_DUTY);
                    den_d   = clamp_freq(I_CMD_FREQ_HZ);
                    num_d   = NUM_W'(CLK_HZ);
                    rem_d   = '0;
                    quo_d   = '0;
                    ready_d = 1'b0;
                    st_d    = ST_DIV_PER;
                end
            end
            ST_DIV_PER: begin
                rem_d = st_res[REM_W-1:0];
                quo_d = quo_nx;
                if (last_step(step_q)) begin
                    // exact integer period: truncation is at most one cycle
                    per_d  = quo_nx[PER_W-1:0];
                    num_d  = NUM_W'(quo_nx[PER_W-1:0]) * NUM_W'(duty_q);
                    den_d  = FREQ_W'(DUTY_FULL);
                    rem_d  = '0;
                    quo_d  = '0;
                    step_d = '0;
                    st_d   = ST_DIV_HI;
                end
            end
            ST_DIV_HI: begin
                rem_d = st_res[REM_W-1:0];
                quo_d = quo_nx;
                if (last_step(step_q)) begin
                    hi_d            = quo_nx[PER_W-1:0];            // a = period*duty/10000
                    load_d[ch_q]    = 1'b1;
                    ready_d         = 1'b1;
                    st_d            = ST_IDLE;
                end
            end
            default: begin
                st_d    = ST_IDLE;
                ready_d = 1'b1;
            end
        endcase
    end

    // command registers; a low clock enable holds every bit
    always_ff @(posedge I_CORE_CLK) begin
        if (!I_RST_N) begin
            st_q    <= ST_IDLE;
            step_q  <= '0;
            rem_q   <= '0;
            num_q   <= '0;
            quo_q   <= '0;
            den_q   <= '0;
            ch_q    <= '0;
            duty_q  <= '0;
            per_q   <= '0;
            hi_q    <= '0;
            load_q  <= '0;
            ready_q <= 1'b0;     // ready rises one cycle after reset release
        end else if (I_CE) begin
            st_q    <= st_d;
            step_q  <= step_d;
            rem_q   <= rem_d;
            num_q   <= num_d;
            quo_q   <= quo_d;
            den_q   <= den_d;
            ch_q    <= ch_d;
            duty_q  <= duty_d;
            per_q   <= per_d;
            hi_q    <= hi_d;
            load_q  <= load_d;
            ready_q <= ready_d;
        end
    end

    // ready leaves straight from its flop
    assign O_CMD_READY = ready_q;

    // ---------------------------------------------------------------
    // channels
    // ---------------------------------------------------------------
    logic [NUM_CH-1:0] pwm;

    // each channel keeps its own settings and counter
    for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
        mcpwm_chan #(
            .PER_W (PER_W)
        ) u_chan (
            .i_clk   (I_CORE_CLK),
            .i_rst_n (I_RST_N),
            .i_ce    (I_CE),
            .i_load  (load_q[g]),
            .i_per   (per_q),
            .i_hi    (hi_q),
            .o_pwm   (pwm[g])
        );
    end

    // ---------------------------------------------------------------
    // output pins
    // ---------------------------------------------------------------

    // pins are plain wires from the channel output flops
    assign O_DOUT5 = pwm[PIN5_CH];
    assign O_DOUT6 = pwm[PIN6_CH];
    assign O_DOUT7 = pwm[PIN7_CH];
    assign O_DOUT8 = pwm[PIN8_CH];

endmodule

// >>> tb_top.sv
// Purpose : self-checking bench for the four-channel pulse width generator
// Assumes : CLK_HZ lowered to 100000 so periods stay short
// Notes   : one load model per channel measures the waveforms
`timescale 1ns/1ps
module tb_top
    import mcpwm_pkg::*;
;
    localparam int CLK = 100000;
    logic clk = 0, rst_n = 0, valid = 0, ce = 1;
    logic [CH_W-1:0] chan = '0;
    logic [DUTY_W-1:0] duty = '0;
    logic [FREQ_W-1:0] freq = '0;
    logic rdy, d5, d6, d7, d8;
    logic [3:0] ch_pin;
    logic [PER_W-1:0] hi[4], per[4];
    int unsigned edg[4];
    int num_errors = 0, total_checks = 0;
    mcpwm_top #(.CLK_HZ(CLK)) mcpwm_top_i (.I_CORE_CLK(clk), .I_RST_N(rst_n), .I_CE(ce),
        .I_CMD_VALID(valid), .I_CMD_CHANNEL(chan), .I_CMD_DUTY(duty), .I_CMD_FREQ_HZ(freq),
        .O_CMD_READY(rdy), .O_DOUT5(d5), .O_DOUT6(d6), .O_DOUT7(d7), .O_DOUT8(d8));
    // index pins by channel so expectations follow the output mapping
    always_comb begin
        ch_pin[PIN5_CH] = d5;
        ch_pin[PIN6_CH] = d6;
        ch_pin[PIN7_CH] = d7;
        ch_pin[PIN8_CH] = d8;
    end
    for (genvar g = 0; g < 4; g++) begin : g_ld
        mcpwm_load mcpwm_load_i (.i_clk(clk), .i_pin(ch_pin[g]), .o_hi(hi[g]), .o_per(per[g]),
            .o_edges(edg[g]));
    end
    initial forever #20 clk = ~clk;
    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic finish_test();
        if (num_errors == 0 && total_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic send(input int ch, input int d, input int f);
        for (int n = 0; n < 200 && rdy !== 1'b1; n++) cyc(1);
        check(rdy, 1);
        valid = 1;
        chan = CH_W'(ch);
        duty = DUTY_W'(d);
        freq = FREQ_W'(f);
        cyc(1);
        valid = 0;
        check(rdy, 0);
    endtask
    task automatic wave(input int ch, input int d, input int f);
        check(32'(per[ch]), CLK / f);
        check(32'(hi[ch]), (CLK / f) * d / 10000);
    endtask
    task automatic wait_rise(input int ch);
        for (int n = 0; n < 2100 && ch_pin[ch] !== 1'b0; n++) cyc(1);
        for (int n = 0; n < 2100 && ch_pin[ch] !== 1'b1; n++) cyc(1);
        check(ch_pin[ch], 1);
        cyc(1);
    endtask
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_channels();
        send(0, 9500, 50);
        send(1, 5000, 50000);
        send(2, 2500, 1000);
        send(3, 1234, 10000);
        cyc(4200);
        wave(0, 9500, 50);
        wave(1, 5000, 50000);
        wave(2, 2500, 1000);
        wave(3, 1234, 10000);
    endtask
    task automatic t_extremes();
        int e2, e3;
        send(1, 5000, 20);
        send(2, 0, 1000);
        send(3, 12000, 60000);
        cyc(300);
        e2 = edg[2];
        e3 = edg[3];
        cyc(4200);
        check(edg[2], e2);
        check(edg[3], e3);
        check(ch_pin[2], 0);
        check(ch_pin[3], 1);
        check(d5, 0);
        check(d6, 1);
        wave(1, 5000, 50);
    endtask
    task automatic t_boundary();
        wait_rise(0);
        cyc(100);
        send(0, 5000, 1000);
        wait_rise(0);
        wave(0, 9500, 50);
        wait_rise(0);
        wave(0, 5000, 1000);
    endtask
    // a low clock enable must hold every pin and keep ready up
    task automatic t_freeze();
        int e0;
        logic [3:0] pins;
        ce = 0;
        cyc(1);
        pins = ch_pin;
        e0 = edg[0];
        cyc(120);
        check(edg[0], e0);
        check(ch_pin, pins);
        check(rdy, 1);
        ce = 1;
        cyc(120);
        check(edg[0] > e0, 1);
    endtask
    initial begin
        cyc(8);
        rst_n = 1;
        check(ch_pin, 0);
        t_channels();
        t_extremes();
        t_boundary();
        t_freeze();
        finish_test();
    end
    initial begin
        repeat (40000) @(posedge clk);
        num_errors++;
        finish_test();
    end
endmodule
bind mcpwm_top mcpwm_monitor mcpwm_monitor_i (.I_CORE_CLK(I_CORE_CLK), .I_RST_N(I_RST_N),
    .I_CMD_VALID(I_CMD_VALID), .I_CMD_CHANNEL(I_CMD_CHANNEL), .O_CMD_READY(O_CMD_READY),
    .O_DOUT5(O_DOUT5), .O_DOUT6(O_DOUT6), .O_DOUT7(O_DOUT7), .O_DOUT8(O_DOUT8));
